// File: rtl/vib_out_pkg.sv
package vib_out_pkg;

  localparam int AXES      = 3;
  localparam int BANDS     = 6;
  localparam int RATE_OPTS = 4;
  localparam int FRAME_BITS = 16;
  localparam int FFT_LEN   = 256;
  localparam int TIME_LEN  = 512;
  localparam int PTR_W     = 9;
  localparam int REC_W     = 4;

  // Register offsets on the serial port
  localparam logic [6:0] OFS_TEMP     = 7'h08;
  localparam logic [6:0] OFS_SUPPLY   = 7'h0a;
  localparam logic [6:0] OFS_BUF_PTR  = 7'h10;
  localparam logic [6:0] OFS_REC_PTR  = 7'h12;
  localparam logic [6:0] OFS_X_BUF    = 7'h14;
  localparam logic [6:0] OFS_Y_BUF    = 7'h16;
  localparam logic [6:0] OFS_Z_BUF    = 7'h18;
  localparam logic [6:0] OFS_GLOBAL_COMMAND = 7'h3e;
  localparam logic [6:0] OFS_X_STAT   = 7'h40;
  localparam logic [6:0] OFS_Y_STAT   = 7'h42;
  localparam logic [6:0] OFS_Z_STAT   = 7'h44;
  localparam logic [6:0] OFS_X_PEAK   = 7'h46;
  localparam logic [6:0] OFS_Y_PEAK   = 7'h48;
  localparam logic [6:0] OFS_Z_PEAK   = 7'h4a;
  localparam logic [6:0] OFS_TIME_LO  = 7'h4c;
  localparam logic [6:0] OFS_TIME_HI  = 7'h4e;
  localparam logic [6:0] OFS_INFO_A   = 7'h6e;
  localparam logic [6:0] OFS_X_BIN    = 7'h70;
  localparam logic [6:0] OFS_Y_BIN    = 7'h72;
  localparam logic [6:0] OFS_Z_BIN    = 7'h74;
  localparam logic [6:0] OFS_INFO_B   = 7'h76;

  // Field positions
  localparam int WARN_BIT_BASE    = 2;
  localparam int CRIT_BIT_BASE    = 3;
  localparam int STAT_UNUSED_BIT  = 3;
  localparam int CMD_RETRIEVE_HI  = 5;
  localparam int FRAME_WRITE_BIT  = 15;

  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [15:0] PEAK_RESET = 16'h0000;
  localparam logic [7:0]  BIN_RESET  = 8'h00;
  localparam logic [15:0] BUF_RESET  = 16'h8000;

  typedef enum logic [1:0] {
    SEV_NONE = 2'b00,
    SEV_WARN = 2'b01,
    SEV_CRIT = 2'b10
  } severity_t;

  typedef struct packed {
    logic [7:0] lower;
    logic [7:0] upper;
  } band_cfg_t;

  typedef struct packed {
    logic [15:0] warn;
    logic [15:0] crit;
  } trig_t;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] peak;
    logic [7:0]  bin;
  } axis_result_t;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] supply;
    logic [15:0] time_lo;
    logic [15:0] time_hi;
    logic [15:0] info_a;
    logic [15:0] info_b;
  } header_t;

  typedef struct packed {
    logic                  valid;
    logic [7:0]            index;
    logic [AXES-1:0][15:0] mag;
  } bin_beat_t;

endpackage

// File: rtl/vib_out_regs.sv
`timescale 1ns/1ps
// Operation
// - Status word holds warning at bit 2n+2, critical at 2n+3 per band.
// - Status bits 2:0 give most critical band; bit 3 reads zero.
// - Bands judged only against definitions of the selected rate option.
// - Y and z status at 0x42 and 0x44, read-only, reset zero.
// - Each axis keeps 16-bit peak magnitude of worst-case alarm.
// - Each axis keeps worst-case FFT bin in bits 7:0; upper byte zero.
// - Y and z peak registers at 0x48 and 0x4a, read-only, reset zero.
// - X and y bin registers at 0x70 and 0x72, read-only, reset zero.
// - Processed data goes to the buffer, and to records when storage selected.
// - Manual time capture holds 512 samples per axis.
// - FFT modes hold a 256-point result per axis.
// - Temperature at 0x08 and supply at 0x0a are readable outputs.
// - Data buffer index pointer at 0x10.
// - FFT record index pointer at 0x12.
// - X, y, z buffer output registers at 0x14, 0x16, 0x18.
// - Record retrieve command accepted through global command at 0x3e.
// - Record time stamp low word at 0x4c, high word at 0x4e.
// - Record header words at 0x6e and 0x76.
// - Each band bounded by lower and upper bin per rate option.
// - Warning and critical conditions may drive the two auxiliary pins.
// - Each axis buffer read advances the buffer index pointer.
module vib_out_regs (
  input  wire logic                          CLK_SYS_I,
  input  wire logic                          RST_B_I,
  input  wire logic                          SPI_SCLK_I,
  input  wire logic                          SPI_CS_B_I,
  input  wire logic                          SPI_DIN_I,
  output logic                               SPI_DOUT_O,
  input  wire vib_out_pkg::bin_beat_t        BIN_I,
  input  wire logic                          RECORD_DONE_I,
  input  wire logic                          TIME_MODE_I,
  input  wire logic                          STORE_SEL_I,
  input  wire logic [1:0]                    RATE_OPT_I,
  input  wire vib_out_pkg::band_cfg_t [3:0][5:0] BAND_CFG_I,
  input  wire vib_out_pkg::trig_t [2:0]      TRIG_I,
  input  wire vib_out_pkg::header_t          HEADER_I,
  input  wire logic                          HEADER_LOAD_I,
  input  wire logic                          SAMPLE_WE_I,
  input  wire logic [8:0]                    SAMPLE_ADDR_I,
  input  wire logic [2:0][15:0]              SAMPLE_DATA_I,
  input  wire logic                          ALARM_IND_EN_I,
  output logic                               AUX_PIN_ONE_O,
  output logic                               AUX_PIN_TWO_O,
  output logic                               RECORD_STORE_O,
  output logic                               RETRIEVE_O,
  output logic [3:0]                         RECORD_SEL_O
);

  localparam int AX = vib_out_pkg::AXES;
  localparam int NB = vib_out_pkg::BANDS;
  localparam int PW = vib_out_pkg::PTR_W;

  // Pin synchronisers; stage one feeds stage two only
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic cs_s1_reg,   cs_s2_reg;
  logic din_s1_reg,  din_s2_reg;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      sclk_s1_reg <= 1'b1;
      sclk_s2_reg <= 1'b1;
      sclk_s3_reg <= 1'b1;
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      din_s1_reg  <= 1'b0;
      din_s2_reg  <= 1'b0;
    end else begin
      sclk_s1_reg <= SPI_SCLK_I;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg   <= SPI_CS_B_I;
      cs_s2_reg   <= cs_s1_reg;
      din_s1_reg  <= SPI_DIN_I;
      din_s2_reg  <= din_s1_reg;
    end
  end

  logic        sel, sclk_rise, sclk_fall, frame_done, is_write;
  logic [15:0] frame_word;
  logic [6:0]  frame_addr, word_addr;
  logic [7:0]  frame_data;
  logic [15:0] rx_reg, tx_reg, rd_word;
  logic [4:0]  bit_cnt_reg;

  assign sel        = !cs_s2_reg;
  assign sclk_rise  = sclk_s2_reg && !sclk_s3_reg;
  assign sclk_fall  = !sclk_s2_reg && sclk_s3_reg;
  assign frame_done = sel && sclk_rise && (bit_cnt_reg == 5'(vib_out_pkg::FRAME_BITS - 1));
  assign frame_word = {rx_reg[14:0], din_s2_reg};
  assign is_write   = frame_word[vib_out_pkg::FRAME_WRITE_BIT];
  assign frame_addr = frame_word[14:8];
  assign frame_data = frame_word[7:0];
  assign word_addr  = {frame_addr[6:1], 1'b0};

  // Receive shifter, mode 3 framing
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      rx_reg      <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end else if (!sel) begin
      bit_cnt_reg <= 5'h00;
    end else if (sclk_rise) begin
      rx_reg      <= frame_word;
      bit_cnt_reg <= frame_done ? 5'h00 : bit_cnt_reg + 5'h01;
    end
  end

  // Read answer leaves in the following frame
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      tx_reg <= 16'h0000;
    end else if (frame_done && !is_write) begin
      tx_reg <= rd_word;
    end else if (sel && sclk_fall && bit_cnt_reg != 5'h00) begin
      tx_reg <= {tx_reg[14:0], 1'b0};
    end
  end

  assign SPI_DOUT_O = tx_reg[15];

  // Alarm evaluation over the streamed spectrum
  logic [AX-1:0][15:0] acc_flags_reg, acc_flags_next;
  logic [AX-1:0][1:0]  acc_sev_q, acc_sev_next;
  logic [AX-1:0][15:0] acc_peak_reg, acc_peak_next;
  logic [AX-1:0][7:0]  acc_bin_reg, acc_bin_next;
  logic [AX-1:0][2:0]  acc_band_reg, acc_band_next;
  vib_out_pkg::axis_result_t [AX-1:0] result_reg;

  function automatic logic in_band(input logic [7:0] idx, input vib_out_pkg::band_cfg_t c);
    in_band = (idx >= c.lower) && (idx <= c.upper);
  endfunction

  function automatic logic [15:0] compose_status(input logic [15:0] f, input logic [2:0] b);
    logic [15:0] w;
    w = f;
    w[vib_out_pkg::STAT_UNUSED_BIT] = 1'b0;
    w[2:0] = b;
    compose_status = w;
  endfunction

  always_comb begin
    logic [1:0] sev;
    logic [2:0] band;
    sev  = 2'b00;
    band = 3'h0;
    acc_flags_next = acc_flags_reg;
    acc_sev_next   = acc_sev_q;
    acc_peak_next  = acc_peak_reg;
    acc_bin_next   = acc_bin_reg;
    acc_band_next  = acc_band_reg;
    if (BIN_I.valid) begin
      for (int a = 0; a < AX; a++) begin
        sev  = vib_out_pkg::SEV_NONE;
        band = 3'h0;
        for (int b = 0; b < NB; b++) begin
          if (in_band(BIN_I.index, BAND_CFG_I[RATE_OPT_I][b])) begin
            if (BIN_I.mag[a] > TRIG_I[a].warn) begin
              acc_flags_next[a][vib_out_pkg::WARN_BIT_BASE + 2*(b+1)] = 1'b1;
              if (sev == vib_out_pkg::SEV_NONE) begin
                sev  = vib_out_pkg::SEV_WARN;
                band = 3'(b + 1);
              end
            end
            if (BIN_I.mag[a] > TRIG_I[a].crit) begin
              acc_flags_next[a][vib_out_pkg::CRIT_BIT_BASE + 2*(b+1)] = 1'b1;
              if (sev != vib_out_pkg::SEV_CRIT) begin
                sev  = vib_out_pkg::SEV_CRIT;
                band = 3'(b + 1);
              end
            end
          end
        end
        // Critical first, then larger magnitude
        if (sev != vib_out_pkg::SEV_NONE && (sev > acc_sev_q[a] ||
            (sev == acc_sev_q[a] && BIN_I.mag[a] > acc_peak_reg[a]))) begin
          acc_sev_next[a]  = sev;
          acc_peak_next[a] = BIN_I.mag[a];
          acc_bin_next[a]  = BIN_I.index;
          acc_band_next[a] = band;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I || RECORD_DONE_I) begin
      acc_flags_reg <= '0;
      acc_sev_q     <= '0;
      acc_peak_reg  <= '0;
      acc_bin_reg   <= '0;
      acc_band_reg  <= '0;
    end else begin
      acc_flags_reg <= acc_flags_next;
      acc_sev_q     <= acc_sev_next;
      acc_peak_reg  <= acc_peak_next;
      acc_bin_reg   <= acc_bin_next;
      acc_band_reg  <= acc_band_next;
    end
  end

  // Whole set commits at once so a read never mixes two records
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      for (int a = 0; a < AX; a++) begin
        result_reg[a].status <= vib_out_pkg::STAT_RESET;
        result_reg[a].peak   <= vib_out_pkg::PEAK_RESET;
        result_reg[a].bin    <= vib_out_pkg::BIN_RESET;
      end
    end else if (RECORD_DONE_I) begin
      for (int a = 0; a < AX; a++) begin
        result_reg[a].status <= compose_status(acc_flags_next[a], acc_band_next[a]);
        result_reg[a].peak   <= acc_peak_next[a];
        result_reg[a].bin    <= acc_bin_next[a];
      end
    end
  end

  // Indicator pins follow the committed flags
  logic any_warn, any_crit;
  always_comb begin
    any_warn = 1'b0;
    any_crit = 1'b0;
    for (int a = 0; a < AX; a++) begin
      for (int b = 1; b <= NB; b++) begin
        any_warn = any_warn | result_reg[a].status[vib_out_pkg::WARN_BIT_BASE + 2*b];
        any_crit = any_crit | result_reg[a].status[vib_out_pkg::CRIT_BIT_BASE + 2*b];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      AUX_PIN_ONE_O <= 1'b0;
      AUX_PIN_TWO_O <= 1'b0;
    end else begin
      AUX_PIN_ONE_O <= ALARM_IND_EN_I && any_warn;
      AUX_PIN_TWO_O <= ALARM_IND_EN_I && any_crit;
    end
  end

  // Sample buffer, sized for the longer time record
  logic [2:0][15:0] buf_mem [vib_out_pkg::TIME_LEN];
  logic [PW-1:0]    ptr_reg;
  logic [3:0]       rec_ptr_reg;
  logic             buf_read;

  always_ff @(posedge CLK_SYS_I) begin
    if (SAMPLE_WE_I) begin
      buf_mem[SAMPLE_ADDR_I] <= SAMPLE_DATA_I;
    end
  end

  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p, input logic tm);
    logic [PW:0] lim;
    lim = tm ? (PW+1)'(vib_out_pkg::TIME_LEN) : (PW+1)'(vib_out_pkg::FFT_LEN);
    ptr_step = ({1'b0, p} + (PW+1)'(1) >= lim) ? '0 : p + PW'(1);
  endfunction

  assign buf_read = frame_done && !is_write && (word_addr == vib_out_pkg::OFS_X_BUF ||
                    word_addr == vib_out_pkg::OFS_Y_BUF || word_addr == vib_out_pkg::OFS_Z_BUF);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I || RECORD_DONE_I) begin
      ptr_reg <= '0;
    end else if (frame_done && is_write && frame_addr == vib_out_pkg::OFS_BUF_PTR) begin
      ptr_reg[7:0] <= frame_data;
    end else if (frame_done && is_write && frame_addr == (vib_out_pkg::OFS_BUF_PTR | 7'h01)) begin
      ptr_reg[PW-1] <= frame_data[0];
    end else if (buf_read) begin
      ptr_reg <= ptr_step(ptr_reg, TIME_MODE_I);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      rec_ptr_reg <= 4'h0;
    end else if (frame_done && is_write && frame_addr == vib_out_pkg::OFS_REC_PTR) begin
      rec_ptr_reg <= frame_data[3:0];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      RETRIEVE_O     <= 1'b0;
      RECORD_STORE_O <= 1'b0;
    end else begin
      RETRIEVE_O     <= frame_done && is_write
                        && frame_addr == (vib_out_pkg::OFS_GLOBAL_COMMAND | 7'h01)
                        && frame_data[vib_out_pkg::CMD_RETRIEVE_HI];
      RECORD_STORE_O <= RECORD_DONE_I && STORE_SEL_I;
    end
  end

  assign RECORD_SEL_O = rec_ptr_reg;

  // Header words refresh per record and on retrieval
  vib_out_pkg::header_t header_reg;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      header_reg <= '0;
    end else if (RECORD_DONE_I || HEADER_LOAD_I) begin
      header_reg <= HEADER_I;
    end
  end

  // Read decode; unmapped addresses answer zero
  always_comb begin
    rd_word = 16'h0000;
    case (word_addr)
      vib_out_pkg::OFS_TEMP:     rd_word = header_reg.temp;
      vib_out_pkg::OFS_SUPPLY:   rd_word = header_reg.supply;
      vib_out_pkg::OFS_BUF_PTR:  rd_word = 16'(ptr_reg);
      vib_out_pkg::OFS_REC_PTR:  rd_word = 16'(rec_ptr_reg);
      vib_out_pkg::OFS_X_BUF:    rd_word = buf_mem[ptr_reg][0];
      vib_out_pkg::OFS_Y_BUF:    rd_word = buf_mem[ptr_reg][1];
      vib_out_pkg::OFS_Z_BUF:    rd_word = buf_mem[ptr_reg][2];
      vib_out_pkg::OFS_X_STAT:   rd_word = result_reg[0].status;
      vib_out_pkg::OFS_Y_STAT:   rd_word = result_reg[1].status;
      vib_out_pkg::OFS_Z_STAT:   rd_word = result_reg[2].status;
      vib_out_pkg::OFS_X_PEAK:   rd_word = result_reg[0].peak;
      vib_out_pkg::OFS_Y_PEAK:   rd_word = result_reg[1].peak;
      vib_out_pkg::OFS_Z_PEAK:   rd_word = result_reg[2].peak;
      vib_out_pkg::OFS_TIME_LO:  rd_word = header_reg.time_lo;
      vib_out_pkg::OFS_TIME_HI:  rd_word = header_reg.time_hi;
      vib_out_pkg::OFS_INFO_A:   rd_word = header_reg.info_a;
      vib_out_pkg::OFS_X_BIN:    rd_word = {8'h00, result_reg[0].bin};
      vib_out_pkg::OFS_Y_BIN:    rd_word = {8'h00, result_reg[1].bin};
      vib_out_pkg::OFS_Z_BIN:    rd_word = {8'h00, result_reg[2].bin};
      vib_out_pkg::OFS_INFO_B:   rd_word = header_reg.info_b;
      default:                   rd_word = 16'h0000;
    endcase
  end

  // Checks
  sequence s_buf_read;
    buf_read && !RECORD_DONE_I;
  endsequence

  sequence s_ptr_next;
    ##1 (ptr_reg == ptr_step($past(ptr_reg), $past(TIME_MODE_I)));
  endsequence

  a_ptr_advance: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    s_buf_read |-> s_ptr_next) else $error("buffer pointer did not advance");

  a_ptr_restart: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    RECORD_DONE_I |=> ptr_reg == '0) else $error("pointer not cleared at record end");

  a_stat_unused: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    result_reg[1].status[vib_out_pkg::STAT_UNUSED_BIT] == 1'b0 && result_reg[1].status[2:0] <= 3'h6)
    else $error("status band field out of range");

  a_band_has_flag: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (result_reg[2].status[2:0] != 3'h0) == (result_reg[2].status[15:4] != 12'h000))
    else $error("band field disagrees with flags");

  a_result_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    !RECORD_DONE_I |=> $stable(result_reg)) else $error("results changed outside record end");

  a_peak_commit: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    RECORD_DONE_I |=> result_reg[0].peak == $past(acc_peak_next[0])
                      && result_reg[0].bin == $past(acc_bin_next[0]))
    else $error("peak or bin not committed");

  a_reset_zero: assert property (@(posedge CLK_SYS_I)
    !RST_B_I |=> result_reg[1].status == vib_out_pkg::STAT_RESET
                 && result_reg[2].peak == vib_out_pkg::PEAK_RESET) else $error("reset value wrong");

  a_aux_crit: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    AUX_PIN_TWO_O |-> $past(ALARM_IND_EN_I) && $past(any_crit)) else $error("aux pin two unjustified");

  a_retrieve_pulse: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    RETRIEVE_O |=> !RETRIEVE_O) else $error("retrieve longer than one cycle");

  a_read_load: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    frame_done && !is_write && word_addr == vib_out_pkg::OFS_Y_STAT
    |=> tx_reg == $past(result_reg[1].status)) else $error("status read not loaded");

endmodule

// File: tb/vib_host_model.sv
`timescale 1ns/1ps
module vib_host_model #(
  parameter int HALF = 6
) (
  input  wire logic        clk_i,
  input  wire logic        dout_i,
  output logic             sclk_o,
  output logic             cs_b_o,
  output logic             din_o,
  output logic             got_o,
  output logic [15:0]      word_o
);
  initial begin
    sclk_o = 1'b1;
    cs_b_o = 1'b1;
    din_o  = 1'b1;
    got_o  = 1'b0;
    word_o = 16'h0000;
  end

  // Mode 3 frame; half period well above the synchroniser delay
  task automatic xfer(input logic [15:0] tx, input logic report);
    logic [15:0] rx;
    rx = 16'h0000;
    @(posedge clk_i);
    cs_b_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      sclk_o <= 1'b0;
      din_o  <= tx[i];
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b1;
      rx[i] = dout_i;
      repeat (HALF) @(posedge clk_i);
    end
    cs_b_o <= 1'b1;
    // Released line must not keep showing the last bit
    din_o  <= ~tx[0];
    word_o <= rx;
    got_o  <= report;
    @(posedge clk_i);
    got_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
  endtask
endmodule

// File: tb/vib_out_regs_tb.sv
`timescale 1ns/1ps
module vib_out_regs_tb;
  logic                              clk;
  logic                              rst_b;
  logic                              sclk;
  logic                              cs_b;
  logic                              din;
  logic                              dout;
  vib_out_pkg::bin_beat_t            beat;
  logic                              rec_done;
  logic                              time_mode;
  logic                              store_sel;
  logic [1:0]                        rate;
  vib_out_pkg::band_cfg_t [3:0][5:0] bands;
  vib_out_pkg::trig_t [2:0]          trig;
  vib_out_pkg::header_t              hdr;
  logic                              hdr_load;
  logic                              s_we;
  logic [8:0]                        s_addr;
  logic [2:0][15:0]                  s_data;
  logic                              ind_en;
  logic                              aux1;
  logic                              aux2;
  logic                              rec_store;
  logic                              retrieve;
  logic [3:0]                        rec_sel;
  logic                              got;
  logic [15:0]                       word;
  logic [15:0]                       exp_q[$];
  logic [2:0][15:0]                  smem[512];
  int                                n_errors;
  int                                cmp_count;
  int                                n_ret;
  int                                n_store;

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  vib_out_regs u_dut (
    .CLK_SYS_I(clk), .RST_B_I(rst_b), .SPI_SCLK_I(sclk), .SPI_CS_B_I(cs_b),
    .SPI_DIN_I(din), .SPI_DOUT_O(dout), .BIN_I(beat), .RECORD_DONE_I(rec_done),
    .TIME_MODE_I(time_mode), .STORE_SEL_I(store_sel), .RATE_OPT_I(rate),
    .BAND_CFG_I(bands), .TRIG_I(trig), .HEADER_I(hdr), .HEADER_LOAD_I(hdr_load),
    .SAMPLE_WE_I(s_we), .SAMPLE_ADDR_I(s_addr), .SAMPLE_DATA_I(s_data),
    .ALARM_IND_EN_I(ind_en), .AUX_PIN_ONE_O(aux1), .AUX_PIN_TWO_O(aux2),
    .RECORD_STORE_O(rec_store), .RETRIEVE_O(retrieve), .RECORD_SEL_O(rec_sel)
  );

  vib_host_model u_host (
    .clk_i(clk), .dout_i(dout), .sclk_o(sclk), .cs_b_o(cs_b), .din_o(din),
    .got_o(got), .word_o(word)
  );

  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic reg_cmp(input logic [15:0] got_v, input logic [15:0] exp_v);
    cmp_count++;
    if (got_v !== exp_v) begin
      n_errors++;
      $display("MISMATCH %0t read %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic pin_cmp(input logic [15:0] got_v, input logic [15:0] exp_v, input string what);
    cmp_count++;
    if (got_v !== exp_v) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got_v, exp_v);
    end
  endtask

  // Read answer arrives in the following frame, hence the filler frame
  task automatic rd(input logic [6:0] ofs, input logic [15:0] exp_v);
    exp_q.push_back(exp_v);
    u_host.xfer({1'b0, ofs, 8'h00}, 1'b0);
    u_host.xfer(16'h0000, 1'b1);
  endtask

  task automatic wr(input logic [6:0] ofs, input logic [7:0] data);
    u_host.xfer({1'b1, ofs, data}, 1'b0);
  endtask

  task automatic chk_hdr();
    rd(vib_out_pkg::OFS_TEMP, hdr.temp);
    rd(vib_out_pkg::OFS_SUPPLY, hdr.supply);
    rd(vib_out_pkg::OFS_TIME_LO, hdr.time_lo);
    rd(vib_out_pkg::OFS_TIME_HI, hdr.time_hi);
    rd(vib_out_pkg::OFS_INFO_A, hdr.info_a);
    rd(vib_out_pkg::OFS_INFO_B, hdr.info_b);
  endtask

  // Peaks placed on purpose; background stays below the warning level
  function automatic logic [15:0] mag_of(input int a, input int b);
    case ({a[1:0], b[7:0]})
      {2'd0, 8'd50}:  return 16'd500;
      {2'd0, 8'd130}: return 16'd2000;
      {2'd1, 8'd250}: return 16'd300;
      {2'd1, 8'd5}:   return 16'd5000;
      {2'd2, 8'd90}:  return 16'd3000;
      {2'd2, 8'd210}: return 16'd4000;
      {2'd2, 8'd255}: return 16'd1500;
      default:        return 16'($urandom_range(99));
    endcase
  endfunction

  always @(posedge clk) begin
    if (retrieve === 1'b1) n_ret++;
    if (rec_store === 1'b1) n_store++;
    if (got === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("MISMATCH %0t unexpected read", $time);
      end else begin
        reg_cmp(word, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    logic [6:0]  aofs[9];
    logic [15:0] aexp[9];
    logic [8:0]  sa[5];
    int          last;
    aofs = '{vib_out_pkg::OFS_X_STAT, vib_out_pkg::OFS_Y_STAT, vib_out_pkg::OFS_Z_STAT,
             vib_out_pkg::OFS_X_PEAK, vib_out_pkg::OFS_Y_PEAK, vib_out_pkg::OFS_Z_PEAK,
             vib_out_pkg::OFS_X_BIN, vib_out_pkg::OFS_Y_BIN, vib_out_pkg::OFS_Z_BIN};
    aexp = '{16'h0313, 16'h4006, 16'hf0c5, 16'h07d0, 16'h012c, 16'h0fa0,
             16'h0082, 16'h00fa, 16'h00d2};
    sa = '{9'd0, 9'd1, 9'd2, 9'd255, 9'd511};
    void'($urandom(32'h92cc));
    rst_b = 1'b0;
    beat = '0;
    rec_done = 1'b0;
    time_mode = 1'b0;
    store_sel = 1'b1;
    rate = 2'd2;
    hdr_load = 1'b0;
    s_we = 1'b0;
    s_addr = '0;
    s_data = '0;
    ind_en = 1'b1;
    // Distinct words per field so a swapped header mapping shows up
    for (int k = 0; k < 6; k++) begin
      hdr[16*k +: 16] = 16'($urandom);
    end
    // Only rate option 2 has narrow bands; the others cover every bin
    for (int r = 0; r < 4; r++) begin
      for (int n = 0; n < 6; n++) begin
        bands[r][n].lower = (r == 2) ? 8'(40 * (n + 1)) : 8'h00;
        bands[r][n].upper = (r == 2 && n < 5) ? 8'(40 * (n + 1) + 30) : 8'hff;
      end
    end
    for (int a = 0; a < 3; a++) begin
      trig[a].warn = 16'd100;
      trig[a].crit = 16'd1000;
    end
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      rd(aofs[i], 16'h0000);
    end
    pin_cmp(16'(aux1), 16'h0000, "aux one idle");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      s_we <= 1'b1;
      s_addr <= sa[i];
      smem[sa[i]] = {16'($urandom), 16'($urandom), 16'($urandom)};
      s_data <= smem[sa[i]];
    end
    @(posedge clk);
    s_we <= 1'b0;
    // Final beat shares its cycle with the record-done pulse
    for (int b = 0; b < 256; b++) begin
      beat.valid <= 1'b1;
      beat.index <= 8'(b);
      for (int a = 0; a < 3; a++) begin
        beat.mag[a] <= mag_of(a, b);
      end
      rec_done <= (b == 255);
      @(posedge clk);
    end
    beat.valid <= 1'b0;
    rec_done <= 1'b0;
    repeat (3) @(posedge clk);
    pin_cmp(16'(n_store), 16'h0001, "record store");
    pin_cmp(16'({aux1, aux2}), 16'h0003, "aux pins set");
    ind_en <= 1'b0;
    repeat (3) @(posedge clk);
    pin_cmp(16'({aux1, aux2}), 16'h0000, "aux pins off");
    for (int i = 0; i < 9; i++) begin
      rd(aofs[i], aexp[i]);
    end
    chk_hdr();
    rd(vib_out_pkg::OFS_X_BUF, smem[0][0]);
    rd(vib_out_pkg::OFS_Y_BUF, smem[1][1]);
    rd(vib_out_pkg::OFS_Z_BUF, smem[2][2]);
    rd(vib_out_pkg::OFS_BUF_PTR, 16'h0003);
    for (int m = 0; m < 2; m++) begin
      time_mode <= m[0];
      last = m ? 511 : 255;
      wr(vib_out_pkg::OFS_BUF_PTR, last[7:0]);
      wr(vib_out_pkg::OFS_BUF_PTR + 7'h01, {7'h00, last[8]});
      rd(vib_out_pkg::OFS_X_BUF, smem[last][0]);
      rd(vib_out_pkg::OFS_BUF_PTR, 16'h0000);
    end
    wr(vib_out_pkg::OFS_REC_PTR, 8'h05);
    rd(vib_out_pkg::OFS_REC_PTR, 16'h0005);
    pin_cmp(16'(rec_sel), 16'h0005, "record select");
    wr(vib_out_pkg::OFS_GLOBAL_COMMAND + 7'h01, 8'h20);
    pin_cmp(16'(n_ret), 16'h0001, "retrieve pulse");
    for (int k = 0; k < 6; k++) begin
      hdr[16*k +: 16] <= 16'($urandom);
    end
    hdr_load <= 1'b1;
    @(posedge clk);
    hdr_load <= 1'b0;
    chk_hdr();
    // Read-only word must ignore a host write
    wr(vib_out_pkg::OFS_Y_STAT, 8'hff);
    rd(vib_out_pkg::OFS_Y_STAT, 16'h4006);
    rd(7'h02, 16'h0000);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
